// [rtl/cpes_event_select.sv]
/*
  Core performance event selector with programmable counters,
  a fixed retired-instruction counter and an identification word.
  Assumes an APB master on pclk and core event inputs from logic
  on the same clock, so no synchroniser sits on them.
*/
// The APB interface to the registers and the register offsets were decided locally.

module cpes_event_select import cpes_pkg::*; #(
  parameter int NCNT = 2
) (
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core pipeline events
  input wire cpes_core_ev_t core_ev
);

  ////////////////////////////////////////////////////////////////////
  // Parameter check
  if (NCNT < 1 || NCNT > MAX_CNT) begin : g_bad_ncnt
    $error("NCNT must be from 1 to MAX_CNT");
  end

  // The increment must hold the largest per-cycle sum of all ports
  if ((2 ** INC_W) - 1 < NPORT * 3) begin : g_bad_inc
    $error("INC_W too narrow for the port sum");
  end

  // Per-counter pairs must stay clear of the fixed registers
  if (int'(SEL_BASE) + int'(REG_STRIDE) * MAX_CNT > int'(FIXED_OFF)) begin : g_bad_map
    $error("Counter pairs overlap the fixed registers");
  end

  ////////////////////////////////////////////////////////////////////
  // State of the block
  typedef struct packed {
    logic [NCNT-1:0][31:0] sel;    // Event select words
    logic [NCNT-1:0][CNT_W-1:0] cnt; // Programmable counts
    logic [NCNT-1:0] prev;         // Last qualified condition
    logic [CNT_W-1:0] fixed;       // Fixed retired count
    logic [31:0] rdata;            // Read data held for the bus
    logic err;                     // Unmapped access flag
    logic ack;                     // Setup seen, answer pending
  } cpes_state_t;

  cpes_state_t st_r;   // Registered state
  cpes_state_t st_nxt; // Next state

  ////////////////////////////////////////////////////////////////////
  // Retired count without faulting special instructions
  function automatic logic [INC_W-1:0] retired_net(cpes_core_ev_t c);
    logic [INC_W-1:0] v;
    v = '0;
    // Subtract the excluded ones, floor at zero
    if (c.ret_all > c.ret_excluded) begin
      v = INC_W'(c.ret_all - c.ret_excluded);
    end
    return v;
  endfunction

  // Sum of port dispatches over a port set
  function automatic logic [INC_W-1:0] port_sum(cpes_core_ev_t c,
                                                logic [NPORT-1:0] set);
    logic [INC_W-1:0] s;
    s = '0;
    for (int i = 0; i < NPORT; i++) begin
      // Only ports in the set add
      if (set[i]) begin
        s = s + INC_W'(c.port_uops[i]);
      end
    end
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Raw event value for an event and mask pair
  function automatic logic [INC_W-1:0] ev_value(logic [7:0] ev,
                                                logic [7:0] um,
                                                cpes_core_ev_t c);
    logic [INC_W-1:0] v;
    v = '0; // Unmatched pairs add nothing
    case (ev)
      EV_DISPATCH: begin
        // Port dispatch sums, one port set per mask
        case (um)
          UM_PORT4: v = port_sum(c, 6'b01_0000);
          UM_NO_P5: v = port_sum(c, 6'b01_1111);
          UM_P5: v = port_sum(c, 6'b10_0000);
          UM_ANY_PORT: v = port_sum(c, 6'b11_1111);
          UM_P015: v = port_sum(c, 6'b10_0011);
          UM_P234: v = port_sum(c, 6'b01_1100);
          default: v = '0;
        endcase
      end
      EV_QUEUE: begin
        // Super queue full, one per cycle
        if (um == UM_QUEUE_FULL) begin
          v = INC_W'(c.super_queue_full);
        end
      end
      EV_SNOOP: begin
        // At most one reply of each kind per cycle
        case (um)
          UM_HIT: v = INC_W'(c.snoop_hit);
          UM_HITE: v = INC_W'(c.snoop_hit_exclusive_reply);
          UM_HITM: v = INC_W'(c.snoop_hit_modified_reply);
          default: v = '0;
        endcase
      end
      EV_RETIRED: begin
        // Retirement classes
        case (um)
          UM_RET_ALL: v = retired_net(c);
          UM_RET_MM: v = INC_W'(c.multimedia_retired);
          UM_RET_FP: v = INC_W'(c.fp_ops_retired);
          default: v = '0;
        endcase
      end
      default: v = '0;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Address decode, shared by reads and writes
  function automatic cpes_reg_kind_t reg_kind(logic [11:0] a);
    cpes_reg_kind_t k;
    k = RK_NONE;
    // Fixed registers first
    if (a == FIXED_OFF) begin
      k = RK_FIXED;
    end else if (a == ID_OFF) begin
      k = RK_ID;
    end
    // Per-counter pairs
    for (int i = 0; i < NCNT; i++) begin
      if (a == SEL_BASE + 12'(i) * REG_STRIDE) begin
        k = RK_SEL;
      end
      if (a == CNT_BASE + 12'(i) * REG_STRIDE) begin
        k = RK_CNT;
      end
    end
    return k;
  endfunction

  // Counter index of a per-counter address
  function automatic int reg_idx(logic [11:0] a);
    int n;
    // Pairs sit one stride apart
    n = int'(a / REG_STRIDE);
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Per-counter qualification
  // Nets, since every generate pass drives its own slice
  wire logic [NCNT-1:0][INC_W-1:0] inc; // Increment this cycle
  wire logic [NCNT-1:0] cond; // Qualified condition now

  for (genvar g = 0; g < NCNT; g++) begin : g_qual
    logic [INC_W-1:0] raw; // Selected event value
    logic [7:0] cmask;     // Threshold
    logic en;              // Counter enable
    logic inv;             // Invert the threshold test
    logic edge_det;        // Count rising edges only
    logic [INC_W-1:0] inc_g; // This counter's increment

    assign raw = ev_value(st_r.sel[g][SEL_EV_LSB +: 8],
                          st_r.sel[g][SEL_UM_LSB +: 8], core_ev);
    assign cmask = st_r.sel[g][SEL_CM_LSB +: 8];
    assign en = st_r.sel[g][SEL_EN_BIT];
    assign inv = st_r.sel[g][SEL_INV_BIT];
    assign edge_det = st_r.sel[g][SEL_EDGE_BIT];

    // Threshold test, optionally inverted
    assign cond[g] = ({3'b000, raw} >= cmask) ^ inv;

    // Weighted when no threshold, else one per cycle or episode
    always_comb begin
      if (!en) begin
        // Disabled counter holds its value
        inc_g = '0;
      end else if (cmask == 8'h00) begin
        // No threshold: add the raw weight
        inc_g = raw;
      end else if (edge_det) begin
        // Count only the first cycle of each episode
        inc_g = INC_W'(cond[g] & ~st_r.prev[g]);
      end else begin
        // One per qualified cycle
        inc_g = INC_W'(cond[g]);
      end
    end

    // Hand the increment to the shared vector
    assign inc[g] = inc_g;
  end

  ////////////////////////////////////////////////////////////////////
  // Next state: counting and register access
  cpes_reg_kind_t kind; // Decoded register kind
  int idx;              // Decoded counter index
  logic setup;          // APB setup cycle
  logic done;           // APB access completes this edge

  assign kind = reg_kind(paddr);
  assign idx = reg_idx(paddr);
  assign setup = psel & ~penable;
  assign done = psel & penable & st_r.ack;

  // Next state: starts from the register, so a low enable freezes all
  always_comb begin
    // Default: hold every field
    st_nxt = st_r;
    if (ce) begin
      // Programmable counters advance; the edge history moves every cycle
      for (int i = 0; i < NCNT; i++) begin
        st_nxt.cnt[i] = st_r.cnt[i] + CNT_W'(inc[i]);
        st_nxt.prev[i] = cond[i];
      end
      // Fixed counter runs on its own in every enabled cycle
      st_nxt.fixed = st_r.fixed + CNT_W'(retired_net(core_ev));
      // Setup: decode and capture read data
      if (setup) begin
        // Answer in the next cycle
        st_nxt.ack = 1'b1;
        // Holes and misaligned addresses are refused
        st_nxt.err = (kind == RK_NONE);
        // Writes and refused reads return zero
        st_nxt.rdata = 32'h0000_0000;
        // Reads sample the register now; the data stand until the next setup
        if (!pwrite) begin
          case (kind)
            RK_SEL: st_nxt.rdata = st_r.sel[idx];
            RK_CNT: st_nxt.rdata = st_r.cnt[idx];
            RK_FIXED: st_nxt.rdata = st_r.fixed;
            RK_ID: st_nxt.rdata = ID_VALUE;
            default: st_nxt.rdata = 32'h0000_0000;
          endcase
        end
      end
      // Access: a write takes effect, bus write wins over counting
      if (done) begin
        // Transfer over, drop the answer
        st_nxt.ack = 1'b0;
        // Only mapped, writable registers take the data
        if (pwrite && !st_r.err) begin
          case (kind)
            RK_SEL: st_nxt.sel[idx] = pwdata;
            RK_CNT: st_nxt.cnt[idx] = pwdata;
            RK_FIXED: st_nxt.fixed = pwdata;
            default: st_nxt.ack = 1'b0; // Identification word ignores writes
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Asynchronous clear to the reset values
      st_r.sel <= {NCNT{SEL_RST}};
      st_r.cnt <= {NCNT{CNT_RST}};
      st_r.prev <= '0;
      st_r.fixed <= CNT_RST;
      st_r.rdata <= 32'h0000_0000;
      st_r.err <= 1'b0;
      st_r.ack <= 1'b0;
    end else begin
      // Take the next state every edge
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus outputs
  // Ready only in an access cycle that follows a taken setup
  assign pready = psel & penable & st_r.ack & ce;
  // Error and read data straight from flip-flops
  assign pslverr = st_r.err;
  assign prdata = st_r.rdata;

endmodule // cpes_event_select

// [rtl/cpes_pkg.sv]
/*
  Shared constants and types of the core event selector.
  Assumes a 32-bit APB register bus and core event inputs on pclk.
*/
package cpes_pkg;

  ////////////////////////////////////////////////////////////////////
  // Widths
  localparam int CNT_W = 32;      // Counter width
  localparam int INC_W = 5;       // Per-cycle increment width
  localparam int NPORT = 6;       // Execution ports
  localparam int MAX_CNT = 4;     // Most counters the map serves

  ////////////////////////////////////////////////////////////////////
  // Event numbers
  localparam logic [7:0] EV_DISPATCH = 8'hB1;
  localparam logic [7:0] EV_QUEUE = 8'hB2;
  localparam logic [7:0] EV_SNOOP = 8'hB8;
  localparam logic [7:0] EV_RETIRED = 8'hC0;

  // Unit masks
  localparam logic [7:0] UM_PORT4 = 8'h10;
  localparam logic [7:0] UM_NO_P5 = 8'h1F;
  localparam logic [7:0] UM_P5 = 8'h20;
  localparam logic [7:0] UM_ANY_PORT = 8'h3F;
  localparam logic [7:0] UM_P015 = 8'h40;
  localparam logic [7:0] UM_P234 = 8'h80;
  localparam logic [7:0] UM_QUEUE_FULL = 8'h01;
  localparam logic [7:0] UM_HIT = 8'h01;
  localparam logic [7:0] UM_HITE = 8'h02;
  localparam logic [7:0] UM_HITM = 8'h04;
  localparam logic [7:0] UM_RET_ALL = 8'h00;
  localparam logic [7:0] UM_RET_MM = 8'h02;
  localparam logic [7:0] UM_RET_FP = 8'h04;

  ////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [11:0] SEL_BASE = 12'h000;
  localparam logic [11:0] CNT_BASE = 12'h004;
  localparam logic [11:0] REG_STRIDE = 12'h008;
  localparam logic [11:0] FIXED_OFF = 12'h040;
  localparam logic [11:0] ID_OFF = 12'h044;

  // Select register fields
  localparam int SEL_EV_LSB = 0;
  localparam int SEL_UM_LSB = 8;
  localparam int SEL_EDGE_BIT = 18;
  localparam int SEL_EN_BIT = 22;
  localparam int SEL_INV_BIT = 23;
  localparam int SEL_CM_LSB = 24;

  // Reset and fixed values
  localparam logic [31:0] SEL_RST = 32'h0000_0000;
  localparam logic [31:0] CNT_RST = 32'h0000_0000;
  localparam logic [31:0] ID_VALUE = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////
  // Register kinds
  typedef enum {RK_NONE, RK_SEL, RK_CNT, RK_FIXED, RK_ID} cpes_reg_kind_t;

  // Core pipeline event inputs
  typedef struct packed {
    logic [NPORT-1:0][1:0] port_uops;
    logic super_queue_full;
    logic snoop_hit;
    logic snoop_hit_exclusive_reply;
    logic snoop_hit_modified_reply;
    logic [2:0] ret_all;
    logic [2:0] ret_excluded;
    logic [2:0] multimedia_retired;
    logic [2:0] fp_ops_retired;
  } cpes_core_ev_t;

endpackage

// [testbench/core_perf_event_select_test.sv]
/*
  Self-checking bench of the event selector.
  Assumes the core model pattern and the bus timing of the hand-over.
*/
module core_perf_event_select_test;
  import cpes_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, run = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rd_e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_d;
  cpes_core_ev_t core_ev;
  int n_fail = 0, checks_done = 0;
  always #12.5 pclk = ~pclk;
  cpes_core_model MODEL (.pclk(pclk), .presetn(presetn), .run(run), .core_ev(core_ev));
  cpes_event_select #(.NCNT(2)) DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_ev(core_ev));
  //////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  // One transfer, entered just after an edge, bounded wait
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      $display("MISMATCH %0t no pready", $time);
      stop_test();
    end
    rd_d = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////
  // Raw per-cycle value of a pair at model phase k
  function automatic int rawv(logic [15:0] eu, int k);
    int v[6];
    for (int p = 0; p < 6; p++) v[p] = (k == 3) ? 0 : (k + p) % 4;
    case (eu)
      {UM_PORT4, EV_DISPATCH}: return v[4];
      {UM_NO_P5, EV_DISPATCH}: return v[0] + v[1] + v[2] + v[3] + v[4];
      {UM_P5, EV_DISPATCH}: return v[5];
      {UM_ANY_PORT, EV_DISPATCH}: return v[0] + v[1] + v[2] + v[3] + v[4] + v[5];
      {UM_P015, EV_DISPATCH}: return v[0] + v[1] + v[5];
      {UM_P234, EV_DISPATCH}: return v[2] + v[3] + v[4];
      {UM_QUEUE_FULL, EV_QUEUE}: return k % 2;
      {UM_HIT, EV_SNOOP}: return int'(k == 0);
      {UM_HITE, EV_SNOOP}: return int'(k == 1);
      {UM_HITM, EV_SNOOP}: return int'(k == 2);
      {UM_RET_ALL, EV_RETIRED}: return k + 2 - int'(k == 3);
      {UM_RET_MM, EV_RETIRED}: return k;
      {UM_RET_FP, EV_RETIRED}: return 3 - k;
      default: return 0;
    endcase
  endfunction
  // Expected count after n pattern cycles, qualifiers applied
  function automatic logic [31:0] expv(logic [31:0] s, int n);
    int r, c, pv, sum;
    // A disabled counter never moves
    if (!s[SEL_EN_BIT]) return 32'h0;
    pv = (0 >= s[31:24]) ^ s[23];
    sum = 0;
    for (int i = 0; i < n; i++) begin
      r = rawv(s[15:0], i % 4);
      c = (r >= s[31:24]) ^ s[23];
      if (s[31:24] == 8'h00) sum += r;
      else sum += s[18] ? (c & !pv) : c;
      pv = c;
    end
    return 32'(sum);
  endfunction
  // Select word: event, mask, edge, invert, threshold, enabled
  function automatic logic [31:0] mk(logic [7:0] ev, um, int e, i, int c);
    return {8'(c), 1'(i), 1'b1, 3'h0, 1'(e), 2'h0, um, ev};
  endfunction
  // Program, clear, run n cycles, read back and compare
  task automatic run_ev(input logic [31:0] s, input logic [11:0] sa, ca, input int n);
    @(posedge pclk);
    bus(1'b1, sa, s);
    @(posedge pclk);
    bus(1'b1, ca, 32'h0);
    run <= 1'b1;
    repeat (n) @(posedge pclk);
    run <= 1'b0;
    bus(1'b0, ca, 32'h0);
    chk(rd_d, expv(s, n));
  endtask
  //////////////////////////////////////////////////////////////////
  // Reset values, identification, refusals, read-back
  task automatic t_bus();
    bus(1'b0, SEL_BASE, 32'h0);
    chk(rd_d, SEL_RST);
    @(posedge pclk);
    bus(1'b1, ID_OFF, 32'hFFFF_FFFF);
    chk({31'h0, rd_e}, 32'h0);
    @(posedge pclk);
    bus(1'b0, ID_OFF, 32'h0);
    chk(rd_d, ID_VALUE);
    chk({31'h0, rd_d[1]}, 32'h0);
    @(posedge pclk);
    bus(1'b0, 12'h002, 32'h0);
    chk({rd_d[31:1], rd_e}, 32'h1);
    @(posedge pclk);
    bus(1'b0, 12'(SEL_BASE + REG_STRIDE * 2), 32'h0);
    chk({31'h0, rd_e}, 32'h1);
    @(posedge pclk);
    bus(1'b1, SEL_BASE + REG_STRIDE, 32'hA5C3_5A3C);
    @(posedge pclk);
    bus(1'b0, SEL_BASE + REG_STRIDE, 32'h0);
    chk(rd_d, 32'hA5C3_5A3C);
    // Freeze mid-transfer: the answer waits for the enable
    @(posedge pclk);
    fork
      bus(1'b0, ID_OFF, 32'h0);
      begin
        @(posedge pclk);
        ce <= 1'b0;
        repeat (3) @(posedge pclk);
        ce <= 1'b1;
      end
    join
    chk(rd_d, ID_VALUE);
  endtask
  // Dispatch events with every qualifier
  task automatic t_dispatch();
    run_ev(mk(EV_DISPATCH, UM_PORT4, 0, 0, 0), SEL_BASE, CNT_BASE, 9);
    run_ev(mk(EV_DISPATCH, UM_NO_P5, 0, 0, 1), SEL_BASE, CNT_BASE, 9);
    run_ev(mk(EV_DISPATCH, UM_NO_P5, 0, 0, 0), SEL_BASE, CNT_BASE, 9);
    run_ev(mk(EV_DISPATCH, UM_NO_P5, 0, 1, 1), SEL_BASE, CNT_BASE, 9);
    run_ev(mk(EV_DISPATCH, UM_NO_P5, 1, 1, 1), SEL_BASE, CNT_BASE, 9);
    run_ev(mk(EV_DISPATCH, UM_ANY_PORT, 0, 0, 8'h07), SEL_BASE, CNT_BASE, 9);
    run_ev(mk(EV_DISPATCH, UM_ANY_PORT, 1, 1, 1), SEL_BASE, CNT_BASE, 9);
    run_ev(mk(EV_DISPATCH, UM_P5, 0, 0, 0), SEL_BASE, CNT_BASE, 9);
    run_ev(mk(EV_DISPATCH, UM_P015, 0, 0, 0), SEL_BASE, CNT_BASE, 9);
    run_ev(mk(EV_DISPATCH, UM_P015, 0, 1, 1), SEL_BASE, CNT_BASE, 9);
    run_ev(mk(EV_DISPATCH, UM_P234, 0, 0, 0), SEL_BASE, CNT_BASE, 9);
  endtask
  // Queue, snoop and retirement events on the second counter, then the retired count on the fixed counter
  task automatic t_other();
    logic [11:0] s1, c1;
    s1 = SEL_BASE + REG_STRIDE;
    c1 = CNT_BASE + REG_STRIDE;
    run_ev(mk(EV_QUEUE, UM_QUEUE_FULL, 0, 0, 0), s1, c1, 10);
    run_ev(mk(EV_SNOOP, UM_HIT, 0, 0, 0), s1, c1, 10);
    run_ev(mk(EV_SNOOP, UM_HITE, 0, 0, 0), s1, c1, 10);
    run_ev(mk(EV_SNOOP, UM_HITM, 0, 0, 0), s1, c1, 10);
    run_ev(mk(EV_QUEUE, 8'h02, 0, 0, 0), s1, c1, 10);
    run_ev(mk(EV_RETIRED, 8'h01, 0, 0, 0), s1, c1, 10);
    run_ev(mk(EV_RETIRED, UM_RET_ALL, 0, 0, 0), s1, c1, 10);
    run_ev(mk(EV_RETIRED, UM_RET_MM, 0, 0, 0), s1, c1, 10);
    run_ev(mk(EV_RETIRED, UM_RET_FP, 0, 0, 0), s1, c1, 10);
    run_ev(mk(EV_QUEUE, UM_QUEUE_FULL, 0, 0, 0) & ~(32'h1 << SEL_EN_BIT), s1, c1, 10);
    run_ev(mk(EV_RETIRED, UM_RET_ALL, 0, 0, 0), SEL_BASE, FIXED_OFF, 11);
  endtask
  // Reset in mid-run clears counts and selects
  task automatic t_reset();
    @(posedge pclk);
    run <= 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b0;
    run <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, FIXED_OFF, 32'h0);
    chk(rd_d, CNT_RST);
    @(posedge pclk);
    bus(1'b0, CNT_BASE + REG_STRIDE, 32'h0);
    chk(rd_d, CNT_RST);
    @(posedge pclk);
    bus(1'b0, SEL_BASE + REG_STRIDE, 32'h0);
    chk(rd_d, SEL_RST);
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_bus();
    t_dispatch();
    t_other();
    t_reset();
    stop_test();
  end
endmodule // core_perf_event_select_test

// [testbench/cpes_core_model.sv]
/*
  Core pipeline model: a four-cycle event pattern while run is high.
  Assumes run changes just after a rising edge of pclk.
*/
module cpes_core_model import cpes_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pattern control
  input wire logic run,
  // Events to the selector
  output cpes_core_ev_t core_ev
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] k_r; // Pattern phase
  // Phase restarts at zero after every idle cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) k_r <= 2'h0;
    else k_r <= run ? k_r + 2'h1 : 2'h0;
  end
  // Idle pipeline reports nothing; phase 3 stalls every port
  always_comb begin
    core_ev = '0;
    if (run) begin
      for (int p = 0; p < NPORT; p++) core_ev.port_uops[p] = (k_r == 2'h3) ? 2'h0 : 2'(k_r + p);
      core_ev.super_queue_full = k_r[0];
      core_ev.snoop_hit = (k_r == 2'h0);
      core_ev.snoop_hit_exclusive_reply = (k_r == 2'h1);
      core_ev.snoop_hit_modified_reply = (k_r == 2'h2);
      core_ev.ret_all = 3'(k_r) + 3'h2;
      core_ev.ret_excluded = {2'h0, k_r == 2'h3};
      core_ev.multimedia_retired = 3'(k_r);
      core_ev.fp_ops_retired = 3'h3 - 3'(k_r);
    end
  end
endmodule // cpes_core_model

// [testbench/cpes_props.sv]
/*
  Bus timing and decode checks of the event selector.
  Bound to cpes_event_select; sees its ports only.
*/
module cpes_props import cpes_pkg::*; #(
  parameter int NCNT = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Bus port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup cycle that the slave takes
  logic setup;
  assign setup = psel && !penable && ce;
  //////////////////////////////////////////////////////////////////
  property p_rdy_idle; !(psel && penable) |-> !pready; endproperty
  a_rdy_idle: assert property (p_rdy_idle) else $error("pready outside access");
  property p_rdy_ce; !ce |-> !pready; endproperty
  a_rdy_ce: assert property (p_rdy_ce) else $error("pready while frozen");
  property p_wait0; setup ##1 (psel && penable && ce) |-> pready; endproperty
  a_wait0: assert property (p_wait0) else $error("access not answered at once");
  property p_mis; setup && paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0; endproperty
  a_mis: assert property (p_mis) else $error("misaligned access not refused");
  property p_range; setup && paddr == 12'(SEL_BASE + REG_STRIDE * NCNT) |=> pslverr; endproperty
  a_range: assert property (p_range) else $error("absent counter not refused");
  property p_ok; setup && (paddr == FIXED_OFF || paddr == ID_OFF) |=> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("mapped access refused");
  property p_id; setup && !pwrite && paddr == ID_OFF |=> prdata == ID_VALUE && !prdata[1];
  endproperty
  a_id: assert property (p_id) else $error("identification word wrong");
  property p_hold; !setup |=> $stable(prdata) && $stable(pslverr); endproperty
  a_hold: assert property (p_hold) else $error("read data moved between setups");
endmodule // cpes_props

bind cpes_event_select cpes_props #(.NCNT(NCNT)) u_props (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));
